// ==== sgpc_regs.vh ====
`ifndef SGPC_REGS_VH
`define SGPC_REGS_VH
// ==========================================================
// register byte offsets
`define SGPC_CFG_OFS 8'h00
`define SGPC_CMD_OFS 8'h04
`define SGPC_TCLOSE_OFS 8'h08
`define SGPC_TOPEN_OFS 8'h0C
`define SGPC_THOLD_OFS 8'h10
`define SGPC_ILOCK_OFS 8'h14
`define SGPC_TRIPSRC_OFS 8'h18
`define SGPC_BO0_OFS 8'h1C
`define SGPC_BO1_OFS 8'h20
`define SGPC_STATUS_OFS 8'h24
// ==========================================================
// configuration fields
`define SGPC_CFG_BREAK 0
`define SGPC_CFG_CTRL 1
`define SGPC_CFG_VISIBLE 2
`define SGPC_CFG_LATCH 3
`define SGPC_CFG_EARTH 4
`define SGPC_CFG_RESET 5'h05
// command fields (write-only pulses)
`define SGPC_CMD_CLOSE 0
`define SGPC_CMD_OPEN 1
// interlock enable fields
`define SGPC_ILK_CLOSE_LSB 0
`define SGPC_ILK_OPEN_LSB 4
`define SGPC_ILK_EXTC 8
`define SGPC_ILK_EXTO 9
// status fields
`define SGPC_ST_READY 2
`define SGPC_ST_WDRAWN 3
`define SGPC_ST_DISTURB 4
`define SGPC_ST_TRIP 5
`define SGPC_ST_CREJ 6
`define SGPC_ST_OREJ 7
// ==========================================================
// position codes
`define SGPC_POS_INDET 2'h0
`define SGPC_POS_OPEN 2'h1
`define SGPC_POS_CLOSED 2'h2
`define SGPC_POS_DISTURB 2'h3
// output relay source codes
`define SGPC_SRC_NONE 3'h0
`define SGPC_SRC_CLOSE 3'h1
`define SGPC_SRC_OPEN 3'h2
`define SGPC_SRC_TRIP 3'h3
// ==========================================================
// timing: times in ms, clock in kHz, counts derived
`define SGPC_CLK_KHZ 40000
`define SGPC_TRAVEL_MS 100
`define SGPC_HOLD_MS 200
`define SGPC_TRAVEL_CYC (`SGPC_TRAVEL_MS * `SGPC_CLK_KHZ)
`define SGPC_HOLD_CYC (`SGPC_HOLD_MS * `SGPC_CLK_KHZ)
`endif

// ==== sgpc_timer.v ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// supervision timer: counts while run is high
module sgpc_timer #(
  parameter W = 24
) (
  input wire mclk_i,
  input wire arst_n_i,
  input wire run_i,
  input wire [W-1:0] limit_i,
  output reg expired_o
);
  reg [W-1:0] cnt; // cycles spent running

  // restart whenever run drops, flag once limit reached
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= {W{1'b0}};
      expired_o <= 1'b0;
    end else if (!run_i) begin
      cnt <= {W{1'b0}};
      expired_o <= 1'b0;
    end else if (cnt >= limit_i) begin
      // hold the flag until run drops
      expired_o <= 1'b1;
    end else begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // sgpc_timer
`default_nettype wire

// ==== sgpc_any_of.v ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// masked or of assignable signals
module sgpc_any_of #(
  parameter N = 3
) (
  input wire [N-1:0] sig_i,
  input wire [N-1:0] en_i,
  output wire any_o
);
  // only assigned signals take part
  assign any_o = |(sig_i & en_i);
endmodule // sgpc_any_of
`default_nettype wire

// ==== sgpc_switchgear_position_control.v ====
// The APB register port and the register offsets were decided locally.
`include "sgpc_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module sgpc_switchgear_position_control #(
  parameter NTRIP = 8,
  parameter TW = 24,
  parameter [TW-1:0] TRAVEL_RESET = `SGPC_TRAVEL_CYC,
  parameter [TW-1:0] HOLD_RESET = `SGPC_HOLD_CYC
) (
  input wire mclk_i,
  input wire arst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // switchgear contacts
  input wire aux_close_i,
  input wire aux_open_i,
  input wire ready_i,
  input wire withdrawn_i,
  // relay-side signals
  input wire external_close_request_i,
  input wire external_open_request_i,
  input wire [2:0] close_interlock_i,
  input wire [2:0] open_interlock_i,
  input wire [NTRIP-1:0] trip_source_i,
  input wire trip_acknowledge_i,
  // results
  output reg [1:0] position_o,
  output reg earthed_o,
  output reg ready_o,
  output reg withdrawn_o,
  output reg disturbed_o,
  output reg close_cmd_o,
  output reg open_cmd_o,
  output reg trip_cmd_o,
  output reg [1:0] bo_o
);
  // ==========================================================
  // registers
  reg [4:0] cfg; // break, controlled, visible, latch, earth
  reg [TW-1:0] t_close; // close travel limit in cycles
  reg [TW-1:0] t_open; // open travel limit in cycles
  reg [TW-1:0] trip_hold_time; // minimum trip hold in cycles
  reg [9:0] ilock_en; // interlock and external enables
  reg [NTRIP-1:0] trip_en; // trip source assignment
  reg [20:0] bo_sel0; // seven 3-bit slots, output 0
  reg [20:0] bo_sel1; // seven 3-bit slots, output 1
  reg disturb_flag; // sticky supervision flag
  reg close_rej; // sticky refused close
  reg open_rej; // sticky refused open
  reg [1:0] cmd_pulse; // panel commands from software
  // ==========================================================
  // bus decode
  wire wr_en = psel_i & penable_i & pready_o & pwrite_i;
  wire wr_cfg = wr_en & (paddr_i == `SGPC_CFG_OFS);
  wire wr_cmd = wr_en & (paddr_i == `SGPC_CMD_OFS);
  wire wr_st = wr_en & (paddr_i == `SGPC_STATUS_OFS);
  reg [31:0] next_rdata; // read mux result
  reg next_err; // unmapped address
  // ==========================================================
  // contact decode and supervision
  wire break_cap = cfg[`SGPC_CFG_BREAK];
  wire controlled = cfg[`SGPC_CFG_CTRL];
  wire both_on = aux_close_i & aux_open_i;
  wire both_off = ~aux_close_i & ~aux_open_i;
  reg last_closed; // last stable position was closed
  wire close_exp; // close travel overrun
  wire open_exp; // open travel overrun
  reg [1:0] next_pos; // decoded position code
  // state of command sequencer
  localparam ST_IDLE = 2'd0;
  localparam ST_CLOSING = 2'd1;
  localparam ST_OPENING = 2'd2;
  reg [1:0] state; // current sequencer state
  reg [1:0] next_state; // next sequencer state
  // ==========================================================
  // travel timers
  // heading to closed when last known open, or commanded so
  wire to_close = (state == ST_CLOSING) | (state == ST_IDLE & ~last_closed);
  wire moving = both_off | (state != ST_IDLE);
  sgpc_timer #(.W(TW)) u_close_tmr (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .run_i(moving & to_close),
    .limit_i(t_close),
    .expired_o(close_exp)
  );
  sgpc_timer #(.W(TW)) u_open_tmr (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .run_i(moving & ~to_close),
    .limit_i(t_open),
    .expired_o(open_exp)
  );
  wire travel_exp = close_exp | open_exp;
  // position code from the two contacts
  always @* begin
    if (both_on)
      next_pos = `SGPC_POS_DISTURB;
    else if (aux_close_i)
      next_pos = `SGPC_POS_CLOSED;
    else if (aux_open_i)
      next_pos = `SGPC_POS_OPEN;
    else if (travel_exp)
      next_pos = `SGPC_POS_DISTURB;
    else
      next_pos = `SGPC_POS_INDET;
  end
  // ==========================================================
  // interlocks and command requests
  wire close_lock; // any enabled close interlock
  wire open_lock; // any enabled open interlock
  sgpc_any_of #(.N(3)) u_close_ilk (
    .sig_i(close_interlock_i),
    .en_i(ilock_en[2:0]),
    .any_o(close_lock)
  );
  sgpc_any_of #(.N(3)) u_open_ilk (
    .sig_i(open_interlock_i),
    .en_i(ilock_en[6:4]),
    .any_o(open_lock)
  );
  wire panel_ok = cfg[`SGPC_CFG_VISIBLE];
  wire req_close = (cmd_pulse[0] & panel_ok) |
    (external_close_request_i & ilock_en[`SGPC_ILK_EXTC]);
  wire req_open = (cmd_pulse[1] & panel_ok) |
    (external_open_request_i & ilock_en[`SGPC_ILK_EXTO]);
  // only a controlled switchgear takes commands
  wire take_close = controlled & req_close & ~close_lock;
  wire take_open = controlled & req_open & ~open_lock;
  // refusals seen while controlled
  wire rej_close = controlled & req_close & close_lock;
  wire rej_open = controlled & req_open & open_lock;
  // sequencer: one movement at a time
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // open wins over close when both asked
        if (take_open)
          next_state = ST_OPENING;
        else if (take_close)
          next_state = ST_CLOSING;
      end
      ST_CLOSING: begin
        // end on arrival, travel overrun or loss of control
        if (next_pos == `SGPC_POS_CLOSED || close_exp || !controlled)
          next_state = ST_IDLE;
      end
      ST_OPENING: begin
        if (next_pos == `SGPC_POS_OPEN || open_exp || !controlled)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end
  // ==========================================================
  // trip manager
  wire trip_any; // any assigned trip source
  sgpc_any_of #(.N(NTRIP)) u_trip_src (
    .sig_i(trip_source_i),
    .en_i(trip_en),
    .any_o(trip_any)
  );
  wire trip_in = trip_any & break_cap;
  reg trip_in_d; // previous trip input
  reg ack_d; // previous acknowledge
  reg ack_seen; // acknowledge arrived in this trip
  wire hold_done; // minimum hold elapsed
  sgpc_timer #(.W(TW)) u_hold_tmr (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .run_i(trip_cmd_o),
    .limit_i(trip_hold_time),
    .expired_o(hold_done)
  );
  wire ack_rise = trip_acknowledge_i & ~ack_d;
  wire release_ok = ~cfg[`SGPC_CFG_LATCH] | ack_seen | ack_rise;
  wire trip_end = hold_done & ~trip_in & release_ok;
  // ==========================================================
  // output relay assignment
  wire [7:0] src_vec; // selectable sources by code
  assign src_vec = {disturbed_o, ready_o, aux_open_i, aux_close_i,
    trip_cmd_o, open_cmd_o, close_cmd_o, 1'b0};
  wire [41:0] bo_sel = {bo_sel1, bo_sel0};
  wire [13:0] slot_hit; // per slot source value
  genvar g;
  generate
    for (g = 0; g < 14; g = g + 1) begin : g_slot
      assign slot_hit[g] = src_vec[bo_sel[3*g+2:3*g]];
    end
  endgenerate
  // ==========================================================
  // read mux
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr_i)
      `SGPC_CFG_OFS: next_rdata[4:0] = cfg;
      `SGPC_CMD_OFS: next_rdata = 32'h00000000;
      `SGPC_TCLOSE_OFS: next_rdata[TW-1:0] = t_close;
      `SGPC_TOPEN_OFS: next_rdata[TW-1:0] = t_open;
      `SGPC_THOLD_OFS: next_rdata[TW-1:0] = trip_hold_time;
      `SGPC_ILOCK_OFS: next_rdata[9:0] = ilock_en;
      `SGPC_TRIPSRC_OFS: next_rdata[NTRIP-1:0] = trip_en;
      `SGPC_BO0_OFS: next_rdata[20:0] = bo_sel0;
      `SGPC_BO1_OFS: next_rdata[20:0] = bo_sel1;
      `SGPC_STATUS_OFS: next_rdata[7:0] = {open_rej, close_rej,
        trip_cmd_o, disturb_flag, withdrawn_o, ready_o, position_o};
      // unmapped: zero data and error
      default: next_err = 1'b1;
    endcase
  end
  // ==========================================================
  // apb answer: pready registered, zero wait states
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      // answer in the access cycle after setup
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & next_err;
      if (psel_i & ~penable_i & ~pwrite_i)
        prdata_o <= next_rdata;
    end
  end
  // ==========================================================
  // software-written configuration
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg <= `SGPC_CFG_RESET;
      t_close <= TRAVEL_RESET;
      t_open <= TRAVEL_RESET;
      trip_hold_time <= HOLD_RESET;
      ilock_en <= 10'h000;
      trip_en <= {NTRIP{1'b0}};
      bo_sel0 <= 21'h000000;
      bo_sel1 <= 21'h000000;
    end else if (wr_en) begin
      case (paddr_i)
        `SGPC_CFG_OFS: cfg <= pwdata_i[4:0];
        `SGPC_TCLOSE_OFS: t_close <= pwdata_i[TW-1:0];
        `SGPC_TOPEN_OFS: t_open <= pwdata_i[TW-1:0];
        `SGPC_THOLD_OFS: trip_hold_time <= pwdata_i[TW-1:0];
        `SGPC_ILOCK_OFS: ilock_en <= pwdata_i[9:0];
        `SGPC_TRIPSRC_OFS: trip_en <= pwdata_i[NTRIP-1:0];
        `SGPC_BO0_OFS: bo_sel0 <= pwdata_i[20:0];
        `SGPC_BO1_OFS: bo_sel1 <= pwdata_i[20:0];
        // other offsets hold no configuration state
        default: cfg <= cfg;
      endcase
    end
  end
  // ==========================================================
  // panel command pulses and sticky flags
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_pulse <= 2'b00;
      disturb_flag <= 1'b0;
      close_rej <= 1'b0;
      open_rej <= 1'b0;
    end else begin
      // one-cycle command from a write
      cmd_pulse <= wr_cmd ? pwdata_i[1:0] : 2'b00;
      if (next_pos == `SGPC_POS_DISTURB)
        disturb_flag <= 1'b1;
      else if (wr_st & pwdata_i[`SGPC_ST_DISTURB])
        disturb_flag <= 1'b0;
      // refusal flags, write one to clear
      if (rej_close)
        close_rej <= 1'b1;
      else if (wr_st & pwdata_i[`SGPC_ST_CREJ])
        close_rej <= 1'b0;
      if (rej_open)
        open_rej <= 1'b1;
      else if (wr_st & pwdata_i[`SGPC_ST_OREJ])
        open_rej <= 1'b0;
    end
  end
  // ==========================================================
  // position, indications, commands
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      position_o <= `SGPC_POS_INDET;
      earthed_o <= 1'b0;
      ready_o <= 1'b0;
      withdrawn_o <= 1'b0;
      disturbed_o <= 1'b0;
      last_closed <= 1'b0;
      state <= ST_IDLE;
      close_cmd_o <= 1'b0;
      open_cmd_o <= 1'b0;
    end else begin
      position_o <= next_pos;
      // closed contact read as earth contact
      earthed_o <= cfg[`SGPC_CFG_EARTH] & aux_close_i & ~aux_open_i;
      ready_o <= ready_i;
      withdrawn_o <= withdrawn_i;
      disturbed_o <= next_pos == `SGPC_POS_DISTURB;
      // remember direction of the next movement
      if (next_pos == `SGPC_POS_CLOSED)
        last_closed <= 1'b1;
      else if (next_pos == `SGPC_POS_OPEN)
        last_closed <= 1'b0;
      state <= next_state;
      close_cmd_o <= next_state == ST_CLOSING;
      open_cmd_o <= next_state == ST_OPENING;
    end
  end
  // ==========================================================
  // trip command and output relays
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trip_in_d <= 1'b0;
      ack_d <= 1'b0;
      ack_seen <= 1'b0;
      trip_cmd_o <= 1'b0;
      bo_o <= 2'b00;
    end else begin
      trip_in_d <= trip_in;
      ack_d <= trip_acknowledge_i;
      if (trip_in & ~trip_in_d)
        trip_cmd_o <= 1'b1;
      else if (trip_cmd_o & trip_end)
        trip_cmd_o <= 1'b0;
      if (!trip_cmd_o || trip_end)
        ack_seen <= 1'b0;
      else if (ack_rise)
        ack_seen <= 1'b1;
      // each output ors its seven slots
      bo_o[0] <= |slot_hit[6:0];
      bo_o[1] <= |slot_hit[13:7];
    end
  end
endmodule // sgpc_switchgear_position_control
`default_nettype wire

// ==== sgpc_switchgear_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker for one switchgear channel
module sgpc_switchgear_asserts #(
  parameter int NTRIP = 8,
  parameter int HOLD = 20
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic aux_close_i,
  input wire logic aux_open_i,
  input wire logic ready_i,
  input wire logic withdrawn_i,
  input wire logic [2:0] close_interlock_i,
  input wire logic [2:0] open_interlock_i,
  input wire logic [NTRIP-1:0] trip_source_i,
  input wire logic [1:0] position_o,
  input wire logic earthed_o,
  input wire logic ready_o,
  input wire logic withdrawn_o,
  input wire logic disturbed_o,
  input wire logic close_cmd_o,
  input wire logic open_cmd_o,
  input wire logic trip_cmd_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // cycles the trip command has stood so far
  int hold_cnt;
  // ==========================================================
  // helper counter, cleared whenever the trip drops
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_cnt <= 0;
    end else if (trip_cmd_o) begin
      hold_cnt <= hold_cnt + 1;
    end else begin
      hold_cnt <= 0;
    end
  end
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_close_go; $rose(close_cmd_o); endsequence
  sequence s_open_go; $rose(open_cmd_o); endsequence
  sequence s_trip_go; $rose(trip_cmd_o); endsequence
  sequence s_trip_end; $fell(trip_cmd_o); endsequence
  // ==========================================================
  // zero wait state bus answer
  a_apb_answer: assert property (s_setup |=> pready_o)
    else $error("no bus answer after setup");
  a_pos_closed: assert property (aux_close_i && !aux_open_i |=> position_o == 2'h2 || earthed_o)
    else $error("closed contact not decoded");
  a_pos_open: assert property (aux_open_i && !aux_close_i |=> position_o == 2'h1)
    else $error("open contact not decoded");
  a_both_disturbed: assert property (aux_open_i && aux_close_i |=> position_o == 2'h3)
    else $error("both contacts not disturbed");
  a_disturb_flag: assert property (disturbed_o == (position_o == 2'h3))
    else $error("disturbed flag differs from state");
  a_inputs_follow: assert property ($past(arst_n_i) |-> ready_o == $past(ready_i) && withdrawn_o == $past(withdrawn_i))
    else $error("ready or withdrawn not reported");
  a_close_ilock: assert property (s_close_go |-> $past(close_interlock_i) == 3'h0)
    else $error("close issued while interlocked");
  a_open_ilock: assert property (s_open_go |-> $past(open_interlock_i) == 3'h0)
    else $error("open issued while interlocked");
  a_trip_cause: assert property (s_trip_go |-> $past(|trip_source_i))
    else $error("trip without a source");
  a_trip_hold: assert property (s_trip_end |-> hold_cnt >= HOLD)
    else $error("trip shorter than hold time");
endmodule // sgpc_switchgear_asserts
bind sgpc_switchgear_position_control sgpc_switchgear_asserts #(
  .NTRIP(NTRIP), .HOLD(HOLD_RESET)
) i_asserts (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .aux_close_i(aux_close_i), .aux_open_i(aux_open_i),
  .ready_i(ready_i), .withdrawn_i(withdrawn_i), .close_interlock_i(close_interlock_i),
  .open_interlock_i(open_interlock_i), .trip_source_i(trip_source_i),
  .position_o(position_o), .earthed_o(earthed_o), .ready_o(ready_o),
  .withdrawn_o(withdrawn_o), .disturbed_o(disturbed_o), .close_cmd_o(close_cmd_o),
  .open_cmd_o(open_cmd_o), .trip_cmd_o(trip_cmd_o)
);
`default_nettype wire

// ==== sgpc_breaker_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// breaker with aux contacts; both contacts open while moving
module sgpc_breaker_model #(
  parameter int MOVE = 10
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic close_cmd_i,
  input wire logic open_cmd_i,
  input wire logic trip_cmd_i,
  input wire logic stuck_i,
  input wire logic fault_i,
  output logic aux_close_o,
  output logic aux_open_o,
  output logic ready_o
);
  logic closed; // settled position
  logic moving; // mechanism in travel
  logic target; // position being travelled to
  int cnt; // travel cycles so far
  // ==========================================================
  // mechanism; a stuck drive never arrives
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      closed <= 1'b0;
      moving <= 1'b0;
      target <= 1'b0;
      cnt <= 0;
    end else if (moving) begin
      cnt <= cnt + 1;
      if (cnt >= MOVE && !stuck_i) begin
        closed <= target;
        moving <= 1'b0;
      end
    end else if (close_cmd_i && !closed) begin
      moving <= 1'b1;
      target <= 1'b1;
      cnt <= 0;
    end else if ((open_cmd_i || trip_cmd_i) && closed) begin
      moving <= 1'b1;
      target <= 1'b0;
      cnt <= 0;
    end
  end
  // a faulty wiring makes both contacts read as made
  assign aux_close_o = fault_i | (closed & ~moving);
  assign aux_open_o = fault_i | (~closed & ~moving);
  // spring charged only while at rest
  assign ready_o = ~moving;
endmodule // sgpc_breaker_model
`default_nettype wire

// ==== sgpc_switchgear_position_control_tb.sv ====
`include "sgpc_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module sgpc_switchgear_position_control_tb;
  localparam int TRAV = 30; // shortened travel count
  localparam int HOLD = 20; // shortened hold count
  logic mclk_i = 1'b0, arst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
  logic pready_o, pslverr_o, rerr, aux_close, aux_open, brk_ready;
  logic withdrawn_i = 1'b0, ext_close = 1'b0, ext_open = 1'b0, ack = 1'b0;
  logic stuck = 1'b0, fault = 1'b0;
  logic [2:0] close_ilk = 3'h0, open_ilk = 3'h0;
  logic [7:0] trip_src = 8'h00;
  logic [1:0] position_o, bo_o;
  logic earthed_o, ready_o, withdrawn_o, disturbed_o, close_cmd_o, open_cmd_o, trip_cmd_o;
  int fail_count = 0, cmp_count = 0, cycles = 0, n;
  sgpc_switchgear_position_control #(.TRAVEL_RESET(24'd30), .HOLD_RESET(24'd20))
  i_sgpc_switchgear_position_control (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .aux_close_i(aux_close),
    .aux_open_i(aux_open), .ready_i(brk_ready), .withdrawn_i(withdrawn_i),
    .external_close_request_i(ext_close), .external_open_request_i(ext_open),
    .close_interlock_i(close_ilk), .open_interlock_i(open_ilk), .trip_source_i(trip_src),
    .trip_acknowledge_i(ack), .position_o(position_o), .earthed_o(earthed_o),
    .ready_o(ready_o), .withdrawn_o(withdrawn_o), .disturbed_o(disturbed_o),
    .close_cmd_o(close_cmd_o), .open_cmd_o(open_cmd_o), .trip_cmd_o(trip_cmd_o), .bo_o(bo_o)
  );
  sgpc_breaker_model #(.MOVE(10)) i_sgpc_breaker_model (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .close_cmd_i(close_cmd_o), .open_cmd_i(open_cmd_o),
    .trip_cmd_i(trip_cmd_o), .stuck_i(stuck), .fault_i(fault), .aux_close_o(aux_close),
    .aux_open_o(aux_open), .ready_o(brk_ready)
  );
  // ==========================================================
  // 40 MHz clock and hang guard
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // one apb transfer; request held until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // one idle edge, so a following call never re-drives psel in this step
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
  endtask
  // bounded wait for a position code
  task automatic wpos(input logic [1:0] p);
    for (int i = 0; i < 60 && position_o !== p; i++) @(posedge mclk_i);
    chk(position_o, p);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(`SGPC_CFG_OFS, 32'hFFFFFFFF, 32'h5);
    rd(`SGPC_TCLOSE_OFS, 32'hFFFFFFFF, TRAV);
    rd(`SGPC_THOLD_OFS, 32'hFFFFFFFF, HOLD);
    rd(`SGPC_STATUS_OFS, 32'h3, 32'h1);
    apb(1'b0, 8'hFC, 32'h0);
    chk(rerr, 1'b1);
    $display("test reset done");
    apb(1'b1, `SGPC_ILOCK_OFS, 32'h377);
    apb(1'b1, `SGPC_TRIPSRC_OFS, 32'hFF);
    apb(1'b1, `SGPC_BO0_OFS, 32'h1);
    apb(1'b1, `SGPC_BO1_OFS, 32'h3);
    apb(1'b1, `SGPC_CFG_OFS, 32'h7);
    ext_close <= 1'b1;
    cyc(1);
    ext_close <= 1'b0;
    cyc(3);
    chk(close_cmd_o, 1'b1);
    chk(bo_o, 2'b01);
    wpos(2'h2);
    apb(1'b1, `SGPC_CFG_OFS, 32'h17);
    cyc(2);
    chk(earthed_o, 1'b1);
    apb(1'b1, `SGPC_CFG_OFS, 32'h7);
    withdrawn_i <= 1'b1;
    cyc(2);
    chk(withdrawn_o, 1'b1);
    rd(`SGPC_STATUS_OFS, 32'hC, 32'hC);
    withdrawn_i <= 1'b0;
    $display("test close done");
    open_ilk <= 3'h4;
    ext_open <= 1'b1;
    cyc(1);
    ext_open <= 1'b0;
    cyc(3);
    chk(open_cmd_o, 1'b0);
    rd(`SGPC_STATUS_OFS, 32'h80, 32'h80);
    open_ilk <= 3'h0;
    apb(1'b1, `SGPC_CMD_OFS, 32'h2);
    cyc(4);
    chk(open_cmd_o, 1'b1);
    wpos(2'h1);
    close_ilk <= 3'h1;
    apb(1'b1, `SGPC_CMD_OFS, 32'h1);
    cyc(4);
    chk(close_cmd_o, 1'b0);
    rd(`SGPC_STATUS_OFS, 32'h40, 32'h40);
    close_ilk <= 3'h0;
    apb(1'b1, `SGPC_CFG_OFS, 32'h3);
    apb(1'b1, `SGPC_CMD_OFS, 32'h1);
    cyc(4);
    chk(close_cmd_o, 1'b0);
    apb(1'b1, `SGPC_CFG_OFS, 32'h5);
    ext_close <= 1'b1;
    cyc(1);
    ext_close <= 1'b0;
    cyc(3);
    chk(close_cmd_o, 1'b0);
    apb(1'b1, `SGPC_CFG_OFS, 32'h4);
    trip_src <= 8'h80;
    ext_close <= 1'b1;
    cyc(4);
    chk({close_cmd_o, trip_cmd_o}, 2'b00);
    ext_close <= 1'b0;
    trip_src <= 8'h00;
    $display("test refusal done");
    apb(1'b1, `SGPC_CFG_OFS, 32'h7);
    trip_src <= 8'h08;
    cyc(2);
    chk(trip_cmd_o, 1'b1);
    trip_src <= 8'h00;
    cyc(1);
    chk(bo_o, 2'b10);
    n = 0;
    while (trip_cmd_o === 1'b1 && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    chk(n >= HOLD && n < 60, 1'b1);
    apb(1'b1, `SGPC_CFG_OFS, 32'hF);
    trip_src <= 8'h01;
    cyc(2);
    trip_src <= 8'h00;
    cyc(40);
    chk(trip_cmd_o, 1'b1);
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(3);
    chk(trip_cmd_o, 1'b0);
    apb(1'b1, `SGPC_CFG_OFS, 32'h6);
    trip_src <= 8'h80;
    cyc(4);
    chk(trip_cmd_o, 1'b0);
    trip_src <= 8'h00;
    $display("test trip done");
    fault <= 1'b1;
    cyc(3);
    chk(position_o, 2'h3);
    chk(disturbed_o, 1'b1);
    rd(`SGPC_STATUS_OFS, 32'h10, 32'h10);
    fault <= 1'b0;
    cyc(3);
    apb(1'b1, `SGPC_STATUS_OFS, 32'h10);
    rd(`SGPC_STATUS_OFS, 32'h13, 32'h1);
    apb(1'b1, `SGPC_CFG_OFS, 32'h7);
    stuck <= 1'b1;
    ext_close <= 1'b1;
    cyc(1);
    ext_close <= 1'b0;
    wpos(2'h3);
    chk(close_cmd_o, 1'b0);
    $display("test disturbed done");
    end_of_test();
  end
endmodule // sgpc_switchgear_position_control_tb
`default_nettype wire
